/* shared/rtc_pkg.sv */
// Constants, types and register map of the I2C real-time clock
package rtc_pkg;
    localparam logic [6:0]  DEV_ADDR    = 7'h32; // Arbitrary target address
    localparam int          SYS_HZ      = 25_000_000;
    localparam int          XTAL_HZ     = 32768;
    localparam int          HALT_US     = 100;
    localparam int          HALT_CYC    = SYS_HZ / 1_000_000 * HALT_US;
    localparam logic [15:0] SEC_TOP     = 16'(XTAL_HZ - 1);
    localparam logic [15:0] HALF_TOP    = 16'(XTAL_HZ / 2 - 1);
    localparam logic [11:0] HALT_TOP    = 12'(HALT_CYC);
    // Register offsets
    localparam logic [3:0]  A_SEC = 4'h0, A_MIN = 4'h1, A_HOUR = 4'h2, A_WDAY = 4'h3;
    localparam logic [3:0]  A_DAY = 4'h4, A_MON = 4'h5, A_YEAR = 4'h6, A_TRIM = 4'h7;
    localparam logic [3:0]  A_WMIN = 4'h8, A_WHOUR = 4'h9, A_WDAYS = 4'ha;
    localparam logic [3:0]  A_DMIN = 4'hb, A_DHOUR = 4'hc, A_CTRL = 4'hd, A_FLAG = 4'he;
    // Control bits: [2:0] period select
    localparam int          C_HALT = 3, C_SUBOFF = 4, C_H24 = 5, C_WEN = 6, C_DEN = 7;
    // Flag bits
    localparam int          F_DAL = 0, F_WAL = 1, F_PER = 2, F_OSC = 3, F_VLOW = 4, F_VSEL = 5;
    localparam int          M_CENT = 7, H_PM = 5;
    localparam logic [7:0]  CTRL_RST = 8'h20;
    localparam logic [7:0]  FLAG_RST = 8'h08;
    localparam logic [7:0]  FLAG_CLR_MASK = 8'h1f;
    typedef enum logic [2:0] {
        PER_OFF = 3'h0, PER_HALF = 3'h1, PER_SEC = 3'h2, PER_MIN = 3'h3,
        PER_HOUR = 3'h4, PER_DAY = 3'h5, PER_MONTH = 3'h6
    } period_e;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_ADDR = 3'h1, S_AACK = 3'h2, S_WR = 3'h3,
        S_WACK = 3'h4, S_RD = 3'h5, S_RACK = 3'h6
    } i2c_state_e;
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] wday;
        logic [7:0] day;
        logic [7:0] mon;
        logic [7:0] year;
    } rtc_time_s;
    localparam rtc_time_s TIME_RST = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
endpackage : rtc_pkg

/* src/rtc_core.sv */
// I2C real-time clock with calendar, alarms, periodic interrupt and monitors
//
// Contract
// - Periodic interrupt: six intervals, 0.5 s to month
// - Periodic flag holds periodic_irq_n low until cleared, released after reset
// - Periodic flag readable; halt bit blocks output
// - Two independent alarm comparators raise interrupts
// - Weekly: day, hour, minute; daily: hour, minute
// - Weekly alarm drives weekly_alarm_irq_n, released after reset
// - Daily alarm drives daily_alarm_irq_n, released after reset
// - Time and calendar counters held in BCD
// - Century bit marks 1900s versus 2000s
// - Leap years handled correctly through 2099
// - Selectable 12-hour or 24-hour counting
// - 32.768 kHz on subclock_out, enabled at reset
// - Host can disable subclock_out toggling
// - Crystal halt recorded in readable flag
// - Supply drop flag, threshold from two settings
// - Host-programmed trim corrects time count
// - I2C target, 7-bit address, up to 400 kHz
// - Host clocks SCL; sample and drive in step
// - Leap year when two-digit year divisible by four
// - Trim about +-189 ppm in 3 ppm steps
// - Weekly alarm accepts any set of days
`timescale 1ns/1ps
`default_nettype none
module rtc_core
    import rtc_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic crystal_in,
    output logic      crystal_out,
    input  wire logic supply_below_high,
    input  wire logic supply_below_low,
    output logic      periodic_irq_n,
    output logic      weekly_alarm_irq_n,
    output logic      daily_alarm_irq_n,
    output logic      subclock_out
);
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    function automatic logic is_leap(input logic [7:0] y);
        is_leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                       : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    endfunction : is_leap

    function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
        unique case (m[4:0])
            5'h02:                            month_end = is_leap(y) ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11:       month_end = 8'h30;
            default:                          month_end = 8'h31;
        endcase
    endfunction : month_end

    // Two-flop synchronisers; the second stage and a delayed copy of it are read
    logic [4:0] meta, sync, sync_d;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            // Supply bits reset low; high would fake a supply drop
            meta   <= 5'h07;
            sync   <= 5'h07;
            sync_d <= 5'h07;
        end else begin
            meta   <= {supply_below_low, supply_below_high, crystal_in, sda_in, scl_in};
            sync   <= meta;
            sync_d <= sync;
        end
    end
    logic scl_s, sda_s, xtal_s, xtal_rise, scl_rise, scl_fall, i2c_start, i2c_stop;
    assign scl_s     = sync[0];
    assign sda_s     = sync[1];
    assign xtal_s    = sync[2];
    assign xtal_rise = sync[2] & ~sync_d[2];
    assign scl_rise  = scl_s & ~sync_d[0];
    assign scl_fall  = ~scl_s & sync_d[0];
    assign i2c_start = scl_s & sync_d[0] & sync_d[1] & ~sda_s;
    assign i2c_stop  = scl_s & sync_d[0] & ~sync_d[1] & sda_s;

    // Prescaler and crystal watchdog
    rtc_time_s  tm, next_tm;
    logic [7:0] trim, ctrl, flags;
    logic [15:0] pre, next_pre, top;
    logic [11:0] idle, next_idle;
    logic        sec_tick, half_tick, osc_dead;
    always_comb begin
        // Trim applied once per ten seconds; one count is about 3 ppm
        top = (tm.sec[3:0] == 4'h0) ? SEC_TOP - 16'({{9{trim[6]}}, trim[6:0]}) : SEC_TOP;
        sec_tick  = xtal_rise && pre >= top;
        half_tick = xtal_rise && pre == HALF_TOP;
        next_pre  = xtal_rise ? (sec_tick ? 16'h0000 : pre + 16'h0001) : pre;
        next_idle = xtal_rise ? 12'h000 : (idle == HALT_TOP ? idle : idle + 12'h001);
        osc_dead  = idle == HALT_TOP;
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pre  <= 16'h0000;
            idle <= 12'h000;
        end else begin
            pre  <= next_pre;
            idle <= next_idle;
        end
    end

    // I2C target
    i2c_state_e st, next_st;
    logic [7:0] sh, next_sh, rdata;
    logic [3:0] ptr, next_ptr, cnt, next_cnt;
    logic       rw, next_rw, have_ptr, next_have_ptr, drv, next_drv, nack, next_nack;
    logic       wr_stb;
    logic [7:0] wmin, whour, wdays, dmin, dhour;
    always_comb begin
        unique case (ptr)
            A_SEC:   rdata = tm.sec;
            A_MIN:   rdata = tm.min;
            A_HOUR:  rdata = tm.hour;
            A_WDAY:  rdata = tm.wday;
            A_DAY:   rdata = tm.day;
            A_MON:   rdata = tm.mon;
            A_YEAR:  rdata = tm.year;
            A_TRIM:  rdata = trim;
            A_WMIN:  rdata = wmin;
            A_WHOUR: rdata = whour;
            A_WDAYS: rdata = wdays;
            A_DMIN:  rdata = dmin;
            A_DHOUR: rdata = dhour;
            A_CTRL:  rdata = ctrl;
            A_FLAG:  rdata = flags;
            default: rdata = 8'h00;
        endcase
    end
    always_comb begin
        next_st = st;
        next_sh = sh;
        next_ptr = ptr;
        next_cnt = cnt;
        next_rw = rw;
        next_have_ptr = have_ptr;
        next_drv = drv;
        next_nack = nack;
        wr_stb = 1'b0;
        if (i2c_stop) begin
            next_st  = S_IDLE;
            next_drv = 1'b0;
        end else if (i2c_start) begin
            next_st  = S_ADDR;
            next_cnt = 4'h0;
            next_drv = 1'b0;
            next_have_ptr = 1'b0;
        end else begin
            unique case (st)
                S_IDLE: ;
                S_ADDR, S_WR: begin
                    if (scl_rise) begin
                        next_sh  = {sh[6:0], sda_s};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == 4'h8) begin
                        if (st == S_ADDR) begin
                            next_rw  = sh[0];
                            next_st  = (sh[7:1] == DEV_ADDR) ? S_AACK : S_IDLE;
                            next_drv = sh[7:1] == DEV_ADDR;
                        end else begin
                            wr_stb   = have_ptr;
                            next_ptr = have_ptr ? ptr + 4'h1 : sh[3:0];
                            next_have_ptr = 1'b1;
                            next_st  = S_WACK;
                            next_drv = 1'b1;
                        end
                    end
                end
                S_AACK, S_WACK: begin
                    if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (rw) begin
                            next_st  = S_RD;
                            next_drv = ~rdata[7];
                            next_sh  = {rdata[6:0], 1'b0};
                            next_ptr = ptr + 4'h1;
                        end else begin
                            next_st  = S_WR;
                            next_drv = 1'b0;
                        end
                    end
                end
                S_RD: begin
                    if (scl_rise) begin
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt == 4'h8) begin
                            next_st  = S_RACK;
                            next_drv = 1'b0;
                        end else begin
                            next_drv = ~sh[7];
                            next_sh  = {sh[6:0], 1'b0};
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise) begin
                        next_nack = sda_s;
                    end else if (scl_fall) begin
                        next_cnt = 4'h0;
                        next_st  = nack ? S_IDLE : S_RD;
                        next_drv = ~nack & ~rdata[7];
                        next_sh  = {rdata[6:0], 1'b0};
                        next_ptr = nack ? ptr : ptr + 4'h1;
                    end
                end
                default: next_st = S_IDLE;
            endcase
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= S_IDLE;
            sh <= 8'h00;
            ptr <= 4'h0;
            cnt <= 4'h0;
            rw <= 1'b0;
            have_ptr <= 1'b0;
            drv <= 1'b0;
            nack <= 1'b0;
        end else begin
            st <= next_st;
            sh <= next_sh;
            ptr <= next_ptr;
            cnt <= next_cnt;
            rw <= next_rw;
            have_ptr <= next_have_ptr;
            drv <= next_drv;
            nack <= next_nack;
        end
    end

    // Timekeeping, alarms, control and flags
    logic [7:0] next_trim, next_ctrl, next_flags, next_wmin, next_whour, next_wdays;
    logic [7:0] next_dmin, next_dhour;
    logic       c_min, c_hour, c_day, c_mon, per_evt, min_tick, next_min_tick, w_hit, d_hit;
    always_comb begin
        next_tm = tm;
        c_min = 1'b0;
        c_hour = 1'b0;
        c_day = 1'b0;
        c_mon = 1'b0;
        if (sec_tick) begin
            next_tm.sec = (tm.sec == 8'h59) ? 8'h00 : bcd_inc(tm.sec);
            c_min = tm.sec == 8'h59;
        end
        if (c_min) begin
            next_tm.min = (tm.min == 8'h59) ? 8'h00 : bcd_inc(tm.min);
            c_hour = tm.min == 8'h59;
        end
        if (c_hour) begin
            if (ctrl[C_H24]) begin
                next_tm.hour = (tm.hour == 8'h23) ? 8'h00 : bcd_inc(tm.hour);
                c_day = tm.hour == 8'h23;
            end else if (tm.hour[4:0] == 5'h12) begin
                next_tm.hour = {tm.hour[7:5], 5'h01};
            end else if (tm.hour[4:0] == 5'h11) begin
                next_tm.hour = {2'b00, ~tm.hour[H_PM], 5'h12};
                c_day = tm.hour[H_PM];
            end else begin
                next_tm.hour = bcd_inc(tm.hour);
            end
        end
        if (c_day) begin
            next_tm.wday = (tm.wday == 8'h06) ? 8'h00 : tm.wday + 8'h01;
            next_tm.day = (tm.day == month_end(tm.mon, tm.year)) ? 8'h01 : bcd_inc(tm.day);
            c_mon = tm.day == month_end(tm.mon, tm.year);
        end
        if (c_mon) begin
            next_tm.mon[6:0] = (tm.mon[4:0] == 5'h12) ? 7'h01 : 7'(bcd_inc({1'b0, tm.mon[6:0]}));
            if (tm.mon[4:0] == 5'h12) begin
                next_tm.year = (tm.year == 8'h99) ? 8'h00 : bcd_inc(tm.year);
                if (tm.year == 8'h99) begin
                    next_tm.mon[M_CENT] = ~tm.mon[M_CENT];
                end
            end
        end
        unique case (period_e'(ctrl[2:0]))
            PER_HALF:  per_evt = half_tick | sec_tick;
            PER_SEC:   per_evt = sec_tick;
            PER_MIN:   per_evt = c_min;
            PER_HOUR:  per_evt = c_hour;
            PER_DAY:   per_evt = c_day;
            PER_MONTH: per_evt = c_mon;
            default:   per_evt = 1'b0;
        endcase
        next_min_tick = c_min;
        // Compare one cycle after the minute rolls so the new time is settled
        w_hit = min_tick && ctrl[C_WEN] && tm.min == wmin && tm.hour == whour
                && wdays[tm.wday[2:0]];
        d_hit = min_tick && ctrl[C_DEN] && tm.min == dmin && tm.hour == dhour;
        next_trim = trim;
        next_ctrl = ctrl;
        next_wmin = wmin;
        next_whour = whour;
        next_wdays = wdays;
        next_dmin = dmin;
        next_dhour = dhour;
        next_flags = flags;
        if (wr_stb) begin
            unique case (ptr)
                A_SEC:   next_tm.sec = sh;
                A_MIN:   next_tm.min = sh;
                A_HOUR:  next_tm.hour = sh;
                A_WDAY:  next_tm.wday = sh;
                A_DAY:   next_tm.day = sh;
                A_MON:   next_tm.mon = sh;
                A_YEAR:  next_tm.year = sh;
                A_TRIM:  next_trim = sh;
                A_WMIN:  next_wmin = sh;
                A_WHOUR: next_whour = sh;
                A_WDAYS: next_wdays = sh;
                A_DMIN:  next_dmin = sh;
                A_DHOUR: next_dhour = sh;
                A_CTRL:  next_ctrl = sh;
                A_FLAG:  next_flags = (flags & sh & FLAG_CLR_MASK) | (sh & 8'h20);
                default: ;
            endcase
        end
        // Set after clear so a coincident event is not lost
        if (d_hit) next_flags[F_DAL] = 1'b1;
        if (w_hit) next_flags[F_WAL] = 1'b1;
        if (per_evt) next_flags[F_PER] = 1'b1;
        if (osc_dead) next_flags[F_OSC] = 1'b1;
        if (flags[F_VSEL] ? sync[4] : sync[3]) next_flags[F_VLOW] = 1'b1;
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tm <= TIME_RST;
            trim <= 8'h00;
            ctrl <= CTRL_RST;
            flags <= FLAG_RST;
            wmin <= 8'h00;
            whour <= 8'h00;
            wdays <= 8'h00;
            dmin <= 8'h00;
            dhour <= 8'h00;
            min_tick <= 1'b0;
        end else begin
            tm <= next_tm;
            trim <= next_trim;
            ctrl <= next_ctrl;
            flags <= next_flags;
            wmin <= next_wmin;
            whour <= next_whour;
            wdays <= next_wdays;
            dmin <= next_dmin;
            dhour <= next_dhour;
            min_tick <= next_min_tick;
        end
    end

    // Pin drivers; open-drain lines only pull low or release
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            periodic_irq_n     <= 1'b1;
            weekly_alarm_irq_n <= 1'b1;
            daily_alarm_irq_n  <= 1'b1;
            subclock_out       <= 1'b1;
            crystal_out        <= 1'b0;
            sda_oe             <= 1'b0;
        end else begin
            periodic_irq_n     <= ~(next_flags[F_PER] & ~ctrl[C_HALT]);
            weekly_alarm_irq_n <= ~next_flags[F_WAL];
            daily_alarm_irq_n  <= ~next_flags[F_DAL];
            subclock_out       <= ctrl[C_SUBOFF] | xtal_s;
            crystal_out        <= ~xtal_s;
            sda_oe             <= next_drv;
        end
    end
    assign sda_out = 1'b0;
endmodule : rtc_core
`default_nettype wire

/* verif/rtc_monitor.sv */
// Pin-level assertions for the real-time clock core
`timescale 1ns/1ps
`default_nettype none
module rtc_monitor (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic crystal_in,
    input wire logic crystal_out,
    input wire logic supply_below_high,
    input wire logic supply_below_low,
    input wire logic periodic_irq_n,
    input wire logic weekly_alarm_irq_n,
    input wire logic daily_alarm_irq_n,
    input wire logic subclock_out
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    a_irq_released: assert property (
        $rose(arst_n) |-> periodic_irq_n && weekly_alarm_irq_n && daily_alarm_irq_n)
        else $error("interrupt line low at reset release");
    a_sub_reset: assert property ($rose(arst_n) |-> subclock_out)
        else $error("subclock low at reset release");
    a_sda_idle: assert property ($rose(arst_n) |-> !sda_oe)
        else $error("data line pulled at reset release");
    a_sda_pull_only: assert property (sda_oe |-> sda_out == 1'b0)
        else $error("data line driven high");
    a_sda_scl_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data changed while clock high");
    a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("data pulled outside clock low");
    // Window of three samples covers the two to three cycle sync latency
    a_sub_fall: assert property ($fell(subclock_out) && $past(arst_n, 4) |->
        !$past(crystal_in, 2) || !$past(crystal_in, 3) || !$past(crystal_in, 4))
        else $error("subclock fell while crystal high");
    a_xtal_feedback: assert property ($past(arst_n, 5) &&
        $past(crystal_in, 2) == $past(crystal_in, 4) |-> crystal_out == !$past(crystal_in, 3))
        else $error("crystal feedback not inverted");
endmodule : rtc_monitor
bind rtc_core rtc_monitor mon (.sys_clk, .arst_n, .scl_in, .sda_in, .sda_out, .sda_oe,
    .crystal_in, .crystal_out, .supply_below_high, .supply_below_low, .periodic_irq_n,
    .weekly_alarm_irq_n, .daily_alarm_irq_n, .subclock_out);
`default_nettype wire

/* verif/i2c_host_model.sv */
// Behavioural bus controller that clocks the clock core
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    input  wire logic sys_clk,
    input  wire logic dev_pull,
    output var logic  scl,
    output wire logic sda
);
    logic drive_low = 1'b0;
    initial scl = 1'b1;
    // Pull-up on the board, so a released line reads high
    assign sda = ~(drive_low | dev_pull);
    task automatic drv(input logic c, input logic low, input int k);
        scl = c;
        drive_low = low;
        repeat (k) @(negedge sys_clk);
    endtask : drv
    task automatic start;
        drv(scl, 1'b0, 2);
        drv(1'b1, 1'b0, 4);
        drv(1'b1, 1'b1, 4);
        drv(1'b0, 1'b1, 2);
    endtask : start
    task automatic stop;
        drv(scl, 1'b1, 2);
        drv(1'b1, 1'b1, 4);
        drv(1'b1, 1'b0, 4);
    endtask : stop
    // Data changes only with the clock low; 320 ns per bit
    task automatic bit_io(input logic b, output logic r);
        drv(1'b0, ~b, 2);
        drv(1'b1, ~b, 2);
        r = sda;
        drv(1'b1, ~b, 2);
        drv(1'b0, ~b, 2);
    endtask : bit_io
    task automatic byte_io(input logic [7:0] w, input logic ack_bit,
                           output logic [7:0] rv, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(w[i], r);
            rv[i] = r;
        end
        bit_io(ack_bit, r);
        ack = ~r;
    endtask : byte_io
endmodule : i2c_host_model
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the real-time clock core
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rtc_pkg::*;
;
    logic       sys_clk    = 1'b0;
    logic       arst_n     = 1'b0;
    logic       crystal_in = 1'b0;
    logic       xtal_run   = 1'b1;
    logic       below_high = 1'b0;
    logic       below_low  = 1'b0;
    wire        scl, sda, sda_out, sda_oe, crystal_out, per_n, wk_n, dy_n, sub;
    int         bad_count  = 0;
    int         comparisons = 0;
    int         cycles     = 0;
    int         seed       = 22716;
    int         sub_edges  = 0;
    int         n, r;
    logic [7:0] d, v, junk;
    logic       ack;
    logic [3:0] alarm_addr [6] = '{A_WMIN, A_WHOUR, A_WDAYS, A_DMIN, A_DHOUR, A_TRIM};
    logic [7:0] time_tab [7] = '{8'h59, 8'h59, 8'h23, 8'h06, 8'h29, 8'h82, 8'h96};

    always #20 sys_clk = ~sys_clk;
    // Crystal edges land on falling clock edges
    always #200 if (xtal_run) crystal_in = ~crystal_in;
    always @(sub) sub_edges++;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            $display("[FAIL] %0t run did not finish", $time);
            bad_count++;
            end_sim();
        end
    end

    rtc_core DUT (.sys_clk, .arst_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
        .crystal_in, .crystal_out, .supply_below_high(below_high),
        .supply_below_low(below_low), .periodic_irq_n(per_n), .weekly_alarm_irq_n(wk_n),
        .daily_alarm_irq_n(dy_n), .subclock_out(sub));
    i2c_host_model host (.sys_clk, .dev_pull(sda_oe), .scl, .sda);

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic send_ptr(input logic [3:0] a);
        host.start();
        host.byte_io({DEV_ADDR, 1'b0}, 1'b1, junk, ack);
        check({7'h0, ack}, 8'h01, "address ack");
        host.byte_io({4'h0, a}, 1'b1, junk, ack);
        check({7'h0, ack}, 8'h01, "pointer ack");
    endtask : send_ptr
    task automatic wr(input logic [3:0] a, input logic [7:0] val);
        send_ptr(a);
        host.byte_io(val, 1'b1, junk, ack);
        host.stop();
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] val);
        send_ptr(a);
        host.start();
        host.byte_io({DEV_ADDR, 1'b1}, 1'b1, junk, ack);
        host.byte_io(8'hff, 1'b1, val, ack);
        host.stop();
    endtask : rd
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] val, input logic [7:0] exp);
        wr(a, val);
        rd(a, d);
        check(d, exp, "register readback");
    endtask : wr_rd
    task automatic idle(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : idle
    function automatic logic [7:0] bcd(input int x);
        return {4'(x / 10), 4'(x % 10)};
    endfunction : bcd
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    initial begin
        idle(8);
        arst_n = 1'b1;
        idle(4);
        rd(A_CTRL, d);
        check(d, CTRL_RST, "control reset");
        rd(A_FLAG, d);
        check(d, FLAG_RST, "flag reset");
        rd(A_DAY, d);
        check(d, 8'h01, "day reset");
        n = sub_edges;
        idle(40);
        check(8'(sub_edges - n > 4), 8'h01, "subclock running");
        $display("reset test done");
        wr(A_CTRL, CTRL_RST | 8'h10);
        n = sub_edges;
        idle(40);
        check({7'h0, sub}, 8'h01, "subclock released");
        check(8'(sub_edges - n), 8'h00, "subclock stopped");
        wr(A_CTRL, CTRL_RST);
        $display("subclock test done");
        for (int i = 0; i < 7; i++)
            wr_rd(4'(i), time_tab[i], time_tab[i]);
        wr(A_CTRL, CTRL_RST & 8'hdf);
        wr_rd(A_HOUR, 8'h31, 8'h31);
        wr(A_CTRL, CTRL_RST);
        $display("time test done");
        for (int i = 0; i < 12; i++) begin
            r = $random(seed) & 32'h7fffffff;
            v = (i % 3 == 0) ? bcd(r % 60) : (i % 3 == 1) ? bcd(r % 24) : 8'(r) & 8'h7f;
            wr_rd(alarm_addr[i % 6], v, v);
        end
        wr_rd(4'hf, 8'h5a, 8'h00);
        host.start();
        host.byte_io({DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, junk, ack);
        host.stop();
        check({7'h0, ack}, 8'h00, "foreign address");
        $display("register test done");
        wr_rd(A_FLAG, 8'h00, 8'h00);
        below_high = 1'b1;
        idle(10);
        rd(A_FLAG, d);
        check(d, 8'h10, "below high threshold");
        // Select first, clear after: a set in the same cycle would win
        wr(A_FLAG, 8'h30);
        wr_rd(A_FLAG, 8'h20, 8'h20);
        below_low = 1'b1;
        idle(10);
        rd(A_FLAG, d);
        check(d, 8'h30, "below low threshold");
        below_high = 1'b0;
        below_low = 1'b0;
        // Threshold select must clear as well as set
        wr_rd(A_FLAG, 8'h00, 8'h00);
        $display("supply test done");
        xtal_run = 1'b0;
        idle(2600);
        rd(A_FLAG, d);
        check(d & 8'h08, 8'h08, "oscillator halt");
        xtal_run = 1'b1;
        check({5'h0, per_n, wk_n, dy_n}, 8'h07, "interrupts released");
        $display("oscillator test done");
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
